// >>> hdl/lrb_debounce.sv
`timescale 1ns/1ns
module lrb_debounce #(
  parameter int CYCLES = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  initial begin
    if (CYCLES < 1 || CYCLES > 255) $error("lrb_debounce: CYCLES out of range");
  end

  logic [7:0] stable_reg;
  logic level_reg;
  wire differs = pin != level_reg;
  wire settled = stable_reg >= 8'(CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      stable_reg <= 8'h00;
      level_reg <= 1'b0;
    end else if (!differs) begin
      stable_reg <= 8'h00;
    end else if (settled) begin
      stable_reg <= 8'h00;
      level_reg <= pin;
    end else begin
      stable_reg <= stable_reg + 8'h01;
    end
  end

  assign level = level_reg;
endmodule

// >>> hdl/lrb_defines.svh
`ifndef LRB_DEFINES_SVH
`define LRB_DEFINES_SVH

// Register offsets
`define LRB_OFS_STRING2 5'h0f
`define LRB_OFS_TEMP 5'h10
`define LRB_OFS_BOOST 5'h11
`define LRB_OFS_LOGIC 5'h12
`define LRB_OFS_ONTIME1 5'h13
`define LRB_OFS_ONTIME2 5'h14
`define LRB_OFS_FAULTS 5'h15
`define LRB_OFS_STATUS 5'h16

// Field positions
`define LRB_PAR_BIT 8
`define LRB_ZERO_BIT 9
`define LRB_F_OPEN1 5
`define LRB_F_SHORT1 4
`define LRB_F_OC1 3
`define LRB_F_OPEN2 2
`define LRB_F_SHORT2 1
`define LRB_F_OC2 0
`define LRB_S_MEMFAIL 7
`define LRB_S_FAILSAFE 6
`define LRB_S_PORFLAG 5
`define LRB_S_PIN1 4
`define LRB_S_PIN2 3
`define LRB_S_FRAMEERR 2
`define LRB_S_TSD 1
`define LRB_S_TW 0

// Reset values
`define LRB_RST_READING 10'h100
`define LRB_RST_ONTIME 10'h100
`define LRB_RST_FAULTS 10'h100

// Thresholds, in codes and periods
`define LRB_TSD_CODE 8'hbd
`define LRB_MEMFAIL_BOOST_CODE 8'h37
`define LRB_OC_BASE_PERIODS 3'h2

// Timing
`define LRB_CLK_NS 40
`define LRB_DEBOUNCE_NS 200
`define LRB_DEBOUNCE_CYC ((`LRB_DEBOUNCE_NS + `LRB_CLK_NS - 1) / `LRB_CLK_NS)
`define LRB_ONTIME_LSB_NS 200
`define LRB_OPEN_LIMIT_NS 50000
`define LRB_OPEN_LIMIT_CNT (`LRB_OPEN_LIMIT_NS / `LRB_ONTIME_LSB_NS)

`endif

// >>> hdl/lrb_pkg.sv
package lrb_pkg;
  typedef logic [9:0] lrb_word_t;
  typedef logic [7:0] lrb_code_t;
  typedef logic [12:0] lrb_milliamp_t;
endpackage

// >>> hdl/lrb_readback_regs.sv
`timescale 1ns/1ns
`include "lrb_defines.svh"
module lrb_readback_regs #(
  parameter int DEBOUNCE_CYC = `LRB_DEBOUNCE_CYC,
  parameter int OPEN_LIMIT_CNT = `LRB_OPEN_LIMIT_CNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register read port
  input wire logic rd_req,
  input wire logic [4:0] rd_addr,
  output logic rd_ack,
  output lrb_pkg::lrb_word_t rd_data,
  // Converter results
  input wire logic [8:0] string_measure_interval,
  input wire logic [1:0] string1_range_select,
  input wire logic [1:0] string2_range_select,
  input wire logic string1_valid,
  input wire lrb_pkg::lrb_code_t string1_voltage_code,
  input wire logic string2_valid,
  input wire lrb_pkg::lrb_code_t string2_voltage_code,
  input wire logic temp_valid,
  input wire lrb_pkg::lrb_code_t die_temp_code,
  input wire logic boost_valid,
  input wire lrb_pkg::lrb_code_t boost_supply_code,
  input wire logic logic_valid,
  input wire lrb_pkg::lrb_code_t logic_supply_code,
  // Buck channel measurements
  input wire logic channel1_on_time_valid,
  input wire lrb_pkg::lrb_code_t channel1_on_time_count,
  input wire logic channel2_on_time_valid,
  input wire lrb_pkg::lrb_code_t channel2_on_time_count,
  input wire logic channel1_period_end,
  input wire lrb_pkg::lrb_milliamp_t channel1_peak_current,
  input wire logic channel2_period_end,
  input wire lrb_pkg::lrb_milliamp_t channel2_peak_current,
  input wire logic [2:0] channel1_current_range,
  input wire logic [2:0] channel2_current_range,
  input wire logic [1:0] overcurrent_period_threshold,
  // Status sources
  input wire logic memory_programming,
  input wire logic failsafe_active,
  input wire logic channel1_control_pin,
  input wire logic channel2_control_pin,
  input wire logic serial_frame_error,
  input wire lrb_pkg::lrb_code_t thermal_warning_threshold
);
  initial begin
    if (OPEN_LIMIT_CNT < 1 || OPEN_LIMIT_CNT > 255) $error("OPEN_LIMIT_CNT out of range");
    if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC > 255) $error("DEBOUNCE_CYC out of range");
  end

  function automatic lrb_pkg::lrb_word_t pack_word(input logic [7:0] payload);
    pack_word = {1'b0, ~^payload, payload};
  endfunction

  // Codes below 1.8 V for each range scale
  function automatic lrb_pkg::lrb_code_t short_limit(input logic [1:0] rng);
    case (rng)
      2'h0: short_limit = 8'h07;
      2'h1: short_limit = 8'h0a;
      2'h2: short_limit = 8'h0c;
      default: short_limit = 8'h10;
    endcase
  endfunction

  function automatic lrb_pkg::lrb_milliamp_t oc_level(input logic [2:0] rng);
    case (rng)
      3'h1: oc_level = 13'd305;
      3'h2: oc_level = 13'd609;
      3'h3: oc_level = 13'd1219;
      3'h4: oc_level = 13'd2437;
      default: oc_level = 13'd4875;
    endcase
  endfunction

  // Saturates rather than wraps, so a lasting excess trips again after a read clear
  function automatic logic [2:0] oc_count(input logic excess, input logic [2:0] cnt);
    if (!excess) begin
      oc_count = 3'h0;
    end else if (cnt == 3'h7) begin
      oc_count = 3'h7;
    end else begin
      oc_count = cnt + 3'h1;
    end
  endfunction

  // Measured codes
  logic [7:0] string2_reg, temp_reg, boost_reg, logic_reg, ontime1_reg, ontime2_reg;
  // Latched flags
  logic [5:0] faults_reg;
  logic memfail_reg, porflag_reg, frameerr_reg, tsd_reg, tw_reg;
  logic [2:0] occnt1_reg, occnt2_reg;
  logic rd_ack_reg;
  lrb_pkg::lrb_word_t rd_data_reg;
  logic pin1_level, pin2_level;

  lrb_debounce #(.CYCLES(DEBOUNCE_CYC)) u_pin1 (
    .clk(clk),
    .rst(rst),
    .pin(channel1_control_pin),
    .level(pin1_level)
  );
  lrb_debounce #(.CYCLES(DEBOUNCE_CYC)) u_pin2 (
    .clk(clk),
    .rst(rst),
    .pin(channel2_control_pin),
    .level(pin2_level)
  );

  // Live register views
  wire [7:0] status_payload = {memfail_reg, failsafe_active, porflag_reg, pin1_level,
    pin2_level, frameerr_reg, tsd_reg, tw_reg};
  wire lrb_pkg::lrb_word_t faults_word = {1'b0, ~^faults_reg, 2'b00, faults_reg};
  wire lrb_pkg::lrb_word_t status_word = pack_word(status_payload);

  wire hit_faults = rd_req && rd_addr == `LRB_OFS_FAULTS;
  wire hit_status = rd_req && rd_addr == `LRB_OFS_STATUS;
  wire addr_mapped = rd_addr >= `LRB_OFS_STRING2 && rd_addr <= `LRB_OFS_STATUS;
  lrb_pkg::lrb_word_t read_mux;
  always_comb begin
    case (rd_addr)
      `LRB_OFS_STRING2: read_mux = pack_word(string2_reg);
      `LRB_OFS_TEMP: read_mux = pack_word(temp_reg);
      `LRB_OFS_BOOST: read_mux = pack_word(boost_reg);
      `LRB_OFS_LOGIC: read_mux = pack_word(logic_reg);
      `LRB_OFS_ONTIME1: read_mux = pack_word(ontime1_reg);
      `LRB_OFS_ONTIME2: read_mux = pack_word(ontime2_reg);
      `LRB_OFS_FAULTS: read_mux = faults_word;
      `LRB_OFS_STATUS: read_mux = status_word;
      default: read_mux = 10'h000;
    endcase
  end

  // Fault detection events
  wire string2_take = string2_valid && string_measure_interval != 9'h000;
  wire string1_take = string1_valid && string_measure_interval != 9'h000;
  wire open1_ev = channel1_on_time_valid && channel1_on_time_count > 8'(OPEN_LIMIT_CNT);
  wire open2_ev = channel2_on_time_valid && channel2_on_time_count > 8'(OPEN_LIMIT_CNT);
  wire short1_ev = string1_take
    && string1_voltage_code < short_limit(string1_range_select);
  wire short2_ev = string2_take
    && string2_voltage_code < short_limit(string2_range_select);
  wire excess1 = channel1_peak_current >= oc_level(channel1_current_range);
  wire excess2 = channel2_peak_current >= oc_level(channel2_current_range);
  wire [2:0] oc_need = `LRB_OC_BASE_PERIODS + {1'b0, overcurrent_period_threshold};
  wire [2:0] occnt1_next = oc_count(excess1, occnt1_reg);
  wire [2:0] occnt2_next = oc_count(excess2, occnt2_reg);
  wire oc1_ev = channel1_period_end && occnt1_next >= oc_need;
  wire oc2_ev = channel2_period_end && occnt2_next >= oc_need;
  wire [5:0] fault_set = {open1_ev, short1_ev, oc1_ev, open2_ev, short2_ev, oc2_ev};
  wire memfail_ev = memory_programming && boost_reg < `LRB_MEMFAIL_BOOST_CODE;
  wire tsd_ev = temp_reg >= `LRB_TSD_CODE;
  wire tw_ev = temp_reg >= thermal_warning_threshold;

  // Set wins over the read clear so no coinciding event is lost
  wire [5:0] faults_next = (faults_reg & ~{6{hit_faults}}) | fault_set;
  wire memfail_next = (memfail_reg & ~hit_status) | memfail_ev;
  wire porflag_next = porflag_reg & ~hit_status;
  wire frameerr_next = (frameerr_reg & ~hit_status) | serial_frame_error;
  wire tsd_next = (tsd_reg & ~hit_status) | tsd_ev;
  wire tw_next = (tw_reg & ~hit_status) | tw_ev;

  always_ff @(posedge clk) begin
    if (rst) begin
      string2_reg <= 8'h00;
      temp_reg <= 8'h00;
      boost_reg <= 8'h00;
      logic_reg <= 8'h00;
    end else begin
      if (string2_take) string2_reg <= string2_voltage_code;
      if (temp_valid) temp_reg <= die_temp_code;
      if (boost_valid) boost_reg <= boost_supply_code;
      if (logic_valid) logic_reg <= logic_supply_code;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // Payload only; the parity one comes from pack_word
      ontime1_reg <= 8'(`LRB_RST_ONTIME);
      ontime2_reg <= 8'(`LRB_RST_ONTIME);
    end else begin
      if (channel1_on_time_valid) ontime1_reg <= channel1_on_time_count;
      if (channel2_on_time_valid) ontime2_reg <= channel2_on_time_count;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      occnt1_reg <= 3'h0;
      occnt2_reg <= 3'h0;
    end else begin
      if (channel1_period_end) occnt1_reg <= occnt1_next;
      if (channel2_period_end) occnt2_reg <= occnt2_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      faults_reg <= 6'h00;
      memfail_reg <= 1'b0;
      porflag_reg <= 1'b1;
      frameerr_reg <= 1'b0;
      tsd_reg <= 1'b0;
      tw_reg <= 1'b0;
    end else begin
      faults_reg <= faults_next;
      memfail_reg <= memfail_next;
      porflag_reg <= porflag_next;
      frameerr_reg <= frameerr_next;
      tsd_reg <= tsd_next;
      tw_reg <= tw_next;
    end
  end

  // Captured from the pre-clear value in the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ack_reg <= 1'b0;
      rd_data_reg <= 10'h000;
    end else begin
      rd_ack_reg <= rd_req;
      if (rd_req) rd_data_reg <= read_mux;
    end
  end

  assign rd_ack = rd_ack_reg;
  assign rd_data = rd_data_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_bit9_parity: assert property (
    rd_req && addr_mapped |=> !rd_data[9] && ^rd_data[8:0])
    else $error("read word bit9 or parity wrong");
  a_unmapped_zero: assert property (rd_req && !addr_mapped |=> rd_data == 10'h000)
    else $error("unmapped offset did not read zero");
  a_string2_hold: assert property (
    string2_valid && string_measure_interval == 9'h000 |=> $stable(string2_reg))
    else $error("string2 updated with zero interval");
  a_string2_take: assert property (
    string2_valid && string_measure_interval != 9'h000
      |=> string2_reg == $past(string2_voltage_code))
    else $error("string2 code not taken");
  a_temp_read: assert property (
    rd_req && rd_addr == `LRB_OFS_TEMP |=> rd_data[7:0] == $past(temp_reg))
    else $error("temperature read mismatch");
  a_boost_read: assert property (
    rd_req && rd_addr == `LRB_OFS_BOOST |=> rd_data[7:0] == $past(boost_reg))
    else $error("boost read mismatch");
  a_logic_read: assert property (
    rd_req && rd_addr == `LRB_OFS_LOGIC |=> rd_data[7:0] == $past(logic_reg))
    else $error("logic supply read mismatch");
  a_ontime_take: assert property (
    channel1_on_time_valid |=> ontime1_reg == $past(channel1_on_time_count))
    else $error("on-time not captured");
  a_ontime2_take: assert property (
    channel2_on_time_valid |=> ontime2_reg == $past(channel2_on_time_count))
    else $error("channel 2 on-time not captured");
  a_ontime_reset: assert property (
    $fell(rst) |-> ontime1_reg == 8'h00 && ontime2_reg == 8'h00)
    else $error("on-time payload not zero after reset");
  a_fault_layout: assert property (
    rd_req && rd_addr == `LRB_OFS_FAULTS |=> rd_data[7:6] == 2'b00
      && rd_data[5:0] == $past(faults_reg))
    else $error("fault register layout wrong");
  a_open_set: assert property (open1_ev |=> faults_reg[`LRB_F_OPEN1])
    else $error("open flag not set");
  a_open2_set: assert property (open2_ev |=> faults_reg[`LRB_F_OPEN2])
    else $error("channel 2 open flag not set");
  a_short_set: assert property (short2_ev |=> faults_reg[`LRB_F_SHORT2])
    else $error("short flag not set");
  a_short1_set: assert property (short1_ev |=> faults_reg[`LRB_F_SHORT1])
    else $error("channel 1 short flag not set");
  a_oc_early: assert property (
    channel1_period_end && occnt1_next < oc_need && !faults_reg[`LRB_F_OC1]
      && !hit_faults |=> !faults_reg[`LRB_F_OC1])
    else $error("overcurrent flag set too early");
  a_oc_trip: assert property (
    channel2_period_end && excess2 && occnt2_reg == 3'h1
      && overcurrent_period_threshold == 2'h0 |=> faults_reg[`LRB_F_OC2])
    else $error("overcurrent flag not set after two periods");
  a_oc_level: assert property (
    channel1_period_end && channel1_current_range == 3'h1
      && channel1_peak_current < 13'd305 |=> occnt1_reg == 3'h0)
    else $error("overcurrent counted below range 1 level");
  a_flag_sticky: assert property (
    faults_reg[`LRB_F_OPEN2] && !hit_faults |=> faults_reg[`LRB_F_OPEN2])
    else $error("fault flag dropped without read");
  a_clear_read: assert property (
    hit_faults && fault_set == 6'h00 |=> faults_reg == 6'h00
      ##0 rd_data[5:0] == $past(faults_reg))
    else $error("clear-on-read misbehaved");
  a_status_par: assert property (
    rd_req && rd_addr == `LRB_OFS_STATUS |=> rd_data[8] == ~^rd_data[7:0])
    else $error("status parity wrong");
  a_fault_par: assert property (
    rd_req && rd_addr == `LRB_OFS_FAULTS |=> rd_data[8] == ~^rd_data[5:0])
    else $error("fault parity wrong");
  a_memfail_set: assert property (memfail_ev |=> memfail_reg)
    else $error("memory failure flag not set");
  a_porflag_reset: assert property ($fell(rst) |-> porflag_reg)
    else $error("power-on flag not set after reset");
  a_porflag_clear: assert property (hit_status |=> !porflag_reg)
    else $error("power-on flag not cleared");
  a_pin_live: assert property (
    $changed(pin1_level) |-> pin1_level == $past(channel1_control_pin))
    else $error("pin level moved away from the pin");
  a_tsd_set: assert property (temp_reg >= `LRB_TSD_CODE |=> tsd_reg)
    else $error("thermal shutdown flag not set");
  a_tw_set: assert property (tw_ev |=> tw_reg)
    else $error("thermal warning flag not set");
  a_event_kept: assert property (hit_status && serial_frame_error |=> frameerr_reg)
    else $error("frame error lost in read clear");

  c_fault_read: cover property (hit_faults && faults_reg != 6'h00);
  c_oc_trip: cover property (oc2_ev);
  c_set_and_clear: cover property (hit_status && memfail_ev);
  c_tw_latch: cover property (tw_ev && !tw_reg);
  c_pin_change: cover property ($changed(pin1_level));
endmodule

// >>> tb/lrb_host_model.sv
`timescale 1ns/1ns
module lrb_host_model (
  // Clock
  input wire logic clk,
  // Read port toward the register block
  output logic rd_req,
  output logic [4:0] rd_addr,
  input wire logic rd_ack,
  input wire lrb_pkg::lrb_word_t rd_data
);
  initial begin
    rd_req = 1'b0;
    rd_addr = 5'h00;
  end

  // One-cycle request; answer taken at the edge that samples rd_ack high
  task automatic read(input logic [4:0] addr, output lrb_pkg::lrb_word_t data);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_addr <= addr;
    @(posedge clk);
    rd_req <= 1'b0;
    // Idle address inverted so a late address decode cannot pass unseen
    rd_addr <= ~addr;
    @(posedge clk);
    data = rd_ack ? rd_data : 'x;
  endtask
endmodule

// >>> tb/lrb_readback_regs_tb.sv
`timescale 1ns/1ns
module lrb_readback_regs_tb;
  logic clk, rst, rd_req, rd_ack, pe, pins;
  logic [4:0] rd_addr;
  lrb_pkg::lrb_word_t rd_data;
  logic [8:0] string_measure_interval;
  logic [1:0] rsel, octhr;
  logic [6:0] vld;
  lrb_pkg::lrb_code_t code, thermal_warning_threshold;
  lrb_pkg::lrb_milliamp_t peak;
  logic [2:0] crange;
  logic memory_programming, failsafe_active, serial_frame_error;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  // All code ports share one bus; only the strobed valid picks it up
  lrb_readback_regs dut_u (
    .clk, .rst, .rd_req, .rd_addr, .rd_ack, .rd_data, .string_measure_interval,
    .string1_range_select(rsel), .string2_range_select(rsel),
    .string1_valid(vld[0]), .string1_voltage_code(code), .string2_valid(vld[1]),
    .string2_voltage_code(code), .temp_valid(vld[2]), .die_temp_code(code),
    .boost_valid(vld[3]), .boost_supply_code(code), .logic_valid(vld[4]),
    .logic_supply_code(code), .channel1_on_time_valid(vld[5]),
    .channel1_on_time_count(code), .channel2_on_time_valid(vld[6]),
    .channel2_on_time_count(code), .channel1_period_end(pe), .channel1_peak_current(peak),
    .channel2_period_end(pe), .channel2_peak_current(peak),
    .channel1_current_range(crange), .channel2_current_range(crange),
    .overcurrent_period_threshold(octhr), .memory_programming, .failsafe_active,
    .channel1_control_pin(pins), .channel2_control_pin(pins), .serial_frame_error,
    .thermal_warning_threshold
  );

  lrb_host_model host_u (.clk, .rd_req, .rd_addr, .rd_ack, .rd_data);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  function automatic lrb_pkg::lrb_word_t wrd(input lrb_pkg::lrb_code_t p);
    return {1'b0, ~^p, p};
  endfunction

  task automatic chk(input logic [4:0] a, input lrb_pkg::lrb_word_t exp);
    lrb_pkg::lrb_word_t got;
    host_u.read(a, got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t addr %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic strobe(input logic [6:0] v, input lrb_pkg::lrb_code_t c);
    @(posedge clk);
    vld <= v;
    code <= c;
    @(posedge clk);
    vld <= 7'h00;
  endtask

  task automatic periods(input int n, input lrb_pkg::lrb_milliamp_t ma);
    repeat (n) begin
      @(posedge clk);
      pe <= 1'b1;
      peak <= ma;
      @(posedge clk);
      pe <= 1'b0;
    end
  endtask

  task automatic t_reset();
    for (int a = 15; a <= 21; a++) chk(5'(a), 10'h100);
    chk(5'h16, 10'h020);
    chk(5'h16, 10'h100);
    chk(5'h1f, 10'h000);
  endtask

  task automatic t_readings();
    lrb_pkg::lrb_code_t tbl[5] = '{8'h5a, 8'h07, 8'hfe, 8'h81, 8'h3c};
    for (int i = 0; i < 5; i++) strobe(7'(4 << i), tbl[i]);
    for (int i = 0; i < 5; i++) chk(5'(16 + i), wrd(tbl[i]));
    strobe(7'h04, 8'h5b);
    chk(5'h10, 10'h05b);
  endtask

  task automatic t_string();
    lrb_pkg::lrb_code_t lim[4] = '{8'h07, 8'h0a, 8'h0c, 8'h10};
    // Interval zero: neither the code nor a short may be taken
    strobe(7'h03, 8'h01);
    chk(5'h0f, 10'h100);
    chk(5'h15, 10'h100);
    @(posedge clk);
    string_measure_interval <= 9'h001;
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      rsel <= 2'(r);
      strobe(7'h03, lim[r]);
      chk(5'h15, 10'h100);
      strobe(7'h03, lim[r] - 8'h01);
      chk(5'h15, 10'h112);
    end
    chk(5'h0f, wrd(8'h0f));
  endtask

  task automatic t_open();
    strobe(7'h60, 8'hfa);
    chk(5'h15, 10'h100);
    strobe(7'h20, 8'hfb);
    strobe(7'h40, 8'hff);
    chk(5'h15, 10'h124);
    chk(5'h15, 10'h100);
    chk(5'h13, wrd(8'hfb));
  endtask

  task automatic t_overcurrent();
    int lvl[5] = '{305, 609, 1219, 2437, 4875};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      crange <= 3'(i + 1);
      octhr <= 2'(i % 4);
      periods(1, 13'h0000);
      periods(1 + i % 4, 13'(lvl[i] + 100));
      periods(1, 13'(lvl[i] - 100));
      periods(1 + i % 4, 13'(lvl[i] + 100));
      chk(5'h15, 10'h100);
      periods(1, 13'(lvl[i] + 100));
      chk(5'h15, 10'h109);
    end
  endtask

  task automatic t_status();
    @(posedge clk);
    memory_programming <= 1'b1;
    failsafe_active <= 1'b1;
    pins <= 1'b1;
    serial_frame_error <= 1'b1;
    thermal_warning_threshold <= 8'h64;
    strobe(7'h08, 8'h36);
    strobe(7'h04, 8'hbd);
    @(posedge clk);
    memory_programming <= 1'b0;
    serial_frame_error <= 1'b0;
    strobe(7'h04, 8'h32);
    repeat (8) @(posedge clk);
    chk(5'h16, 10'h0df);
    chk(5'h16, 10'h058);
    @(posedge clk);
    failsafe_active <= 1'b0;
    pins <= 1'b0;
    repeat (8) @(posedge clk);
    chk(5'h16, 10'h100);
  endtask

  task automatic t_coincide();
    fork
      chk(5'h15, 10'h100);
      strobe(7'h20, 8'hff);
    join
    chk(5'h15, 10'h020);
  endtask

  task automatic end_sim();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    pe = 1'b0;
    pins = 1'b0;
    vld = 7'h00;
    code = 8'h00;
    peak = 13'h0000;
    rsel = 2'h0;
    octhr = 2'h0;
    crange = 3'h1;
    string_measure_interval = 9'h000;
    thermal_warning_threshold = 8'hff;
    memory_programming = 1'b0;
    failsafe_active = 1'b0;
    serial_frame_error = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_readings();
    t_string();
    t_open();
    t_overcurrent();
    t_status();
    t_coincide();
    end_sim();
  end
endmodule
